//--- pkg/tcd_params.svh
// Purpose: Offsets, field positions, reset values and codes of the timer control block.
// Assumes: 8-bit byte addresses on APB, one 32-bit word per register.
// Notes: Included by tcd_pkg only.
`ifndef TCD_PARAMS_SVH
`define TCD_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define TCD_CNT_W 16
`define TCD_AW 8

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TCD_OFF_CTL0 8'h00
`define TCD_OFF_MSTR 8'h04
`define TCD_OFF_SLV 8'h08
`define TCD_OFF_DMAEN 8'h0C
`define TCD_OFF_STAT 8'h10
`define TCD_OFF_DBG 8'h14
`define TCD_OFF_CNT 8'h24
`define TCD_OFF_PSC 8'h28
`define TCD_OFF_CAR 8'h2C
`define TCD_OFF_CV0 8'h34
`define TCD_OFF_DMA_CONFIGURATION 8'h48
`define TCD_OFF_DMA_TRANSFER_BUFFER 8'h4C

// ****************************************************************
// Control register 0 fields
// ****************************************************************
`define TCD_CTL0_W 10
`define TCD_CTL0_RST 10'h000
`define TCD_CEN 0
`define TCD_UPDIS 1
`define TCD_SPM 3
`define TCD_DIR 4
`define TCD_CAM 6:5
`define TCD_RELOAD_SHADOW_ENABLE 7
`define TCD_SAMPLE_CLOCK_DIVIDE 9:8

// ****************************************************************
// Own register fields and codes
// ****************************************************************
`define TCD_MSTR_F 6:4
`define TCD_SLV_MODE 2:0
`define TCD_SLV_TSEL 7:4
`define TCD_DCFG_TA 4:0
`define TCD_DCFG_TC 12:8
`define TCD_MTS_RUN 3'h1
`define TCD_MTS_UPD 3'h2
`define TCD_MTS_OC0 3'h4
`define TCD_SM_EXT1 3'h1
`define TCD_SM_PAUSE 3'h2
`define TCD_SM_EVENT 3'h3
`define TCD_TS_EXT 4'h1
`define TCD_TS_EVT 4'h3
`define TCD_CAM_EDGE 2'h0
`define TCD_CAM_DOWN 2'h1
`define TCD_CAM_UP 2'h2
`define TCD_SAMPLE_CLOCK_DIVIDE_2 2'h1
`define TCD_SAMPLE_CLOCK_DIVIDE_4 2'h2
`define TCD_CNT_RST 16'h0000
`define TCD_CAR_RST 16'hFFFF

`endif

//--- pkg/tcd_pkg.sv
// Purpose: Types shared by the timer control block.
// Assumes: Constants come from tcd_params.svh.
// Notes: None.
package tcd_pkg;
`include "tcd_params.svh"

    typedef logic [`TCD_CNT_W-1:0] tcd_cnt_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`TCD_AW-1:0] paddr;
        logic [31:0] pwdata;
    } tcd_apb_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcd_apb_rsp_s;

    typedef struct packed {
        logic [`TCD_CTL0_W-1:0] ctl0;
        logic [2:0] mts;
        logic [2:0] smode;
        logic [3:0] tsel;
        logic [1:0] dmaen;
        logic [1:0] flags;
        logic hold;
        tcd_cnt_t cnt;
        tcd_cnt_t psc;
        tcd_cnt_t auto_reload_value;
        tcd_cnt_t car_sh;
        tcd_cnt_t cv;
        logic dir_hw;
        logic ocref;
        logic trg_q;
        logic trgo;
        logic [4:0] dma_ta;
        logic [4:0] dma_tc;
        logic [4:0] dma_idx;
        logic [4:0] dma_left;
        logic dma_pend;
        logic dma_req;
        logic [31:0] rdata;
    } tcd_state_s;

endpackage : tcd_pkg

//--- rtl/tcd_tick_div.sv
// Purpose: Enable divider giving one tick every ratio+1 enabled cycles.
// Assumes: Single clock; en marks the cycles that count.
// Notes: A ratio of zero ticks on every enabled cycle.
`timescale 1ns/100ps
module tcd_tick_div #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic en,
    input wire logic [W-1:0] ratio,
    // Tick
    output logic tick
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    assign tick = en && (cnt_q >= ratio);

    always_comb
    begin
        cnt_d = cnt_q;
        if (en)
        begin
            cnt_d = (cnt_q >= ratio) ? '0 : cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end
endmodule : tcd_tick_div

//--- rtl/tcd_timer_ctl.sv
// Purpose: Timer counter core with chaining, burst DMA remap, debug hold and control 0.
// Assumes: APB slave with zero wait states; trigger and halt come from pclk logic.
// Notes: Read data is captured in the setup cycle and shown in the access cycle.
`timescale 1ns/100ps
// Functional notes
// - Trigger select 010 outputs update pulse
// - Trigger select 001 outputs counter run state
// - Trigger select 100 outputs channel 0 reference
// - External clock mode counts trigger rising edges
// - Event mode trigger sets run bit
// - Event mode resumes without clearing counter
// - Trigger code 0011 selects master for event
// - Pause mode counts only while trigger high
// - Enabled event raises a DMA request
// - Buffer access is redirected to selected register
// - Burst issues count plus one requests
// - Burst target advances one word each access
// - New event restarts burst from start
// - Debug halt with hold bit stops counter
// - Sample clock divides by one, two, four
// - Shadow bit buffers the reload value
// - Code 00 is edge aligned using direction
// - Code 01 flags compare only counting down
// - Code 10 flags compare only counting up
// - Code 11 flags compare both directions
// - Alignment locked edge aligned while running
// - Direction bit read only when center aligned
module tcd_timer_ctl
    import tcd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire tcd_apb_s apb_i,
    output tcd_apb_rsp_s apb_o,
    // Chaining
    input wire logic trig_in,
    output logic trgo,
    // DMA and debug
    output logic dma_req,
    input wire logic dbg_halt,
    // Sample clock enable
    output logic dts_tick
);
    tcd_state_s q;
    tcd_state_s d;
    logic [`TCD_AW-1:0] a;
    logic [4:0] tgt;
    logic [31:0] rd_val;
    logic rd_hit;
    logic wr_acc;
    logic tb_acc;
    logic trig_c;
    logic trig_rise;
    logic halted;
    logic src_en;
    logic pre_tick;
    logic upd;
    logic cmp;
    logic [1:0] count_alignment_select;
    logic dir;
    logic [1:0] dts_ratio;
    logic [31:0] wd;
    tcd_cnt_t arr;

    // ****************************************************************
    // Bus decode and buffer remapping
    // ****************************************************************
    assign tgt = q.dma_ta + q.dma_idx;
    assign a = (apb_i.paddr == `TCD_OFF_DMA_TRANSFER_BUFFER) ? {1'b0, tgt, 2'b00} : apb_i.paddr;
    assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign tb_acc = apb_i.psel && apb_i.penable && (apb_i.paddr == `TCD_OFF_DMA_TRANSFER_BUFFER);
    assign wd = apb_i.pwdata;
    assign count_alignment_select = q.ctl0[`TCD_CAM];
    assign dir = (count_alignment_select == `TCD_CAM_EDGE) ? q.ctl0[`TCD_DIR] : q.dir_hw;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (a)
            `TCD_OFF_CTL0: rd_val = {22'h00_0000, q.ctl0[9:5], dir, q.ctl0[3:0]};
            `TCD_OFF_MSTR: rd_val = {25'h000_0000, q.mts, 4'h0};
            `TCD_OFF_SLV: rd_val = {24'h00_0000, q.tsel, 1'b0, q.smode};
            `TCD_OFF_DMAEN: rd_val = {30'h0000_0000, q.dmaen};
            `TCD_OFF_STAT: rd_val = {30'h0000_0000, q.flags};
            `TCD_OFF_DBG: rd_val = {31'h0000_0000, q.hold};
            `TCD_OFF_CNT: rd_val = {16'h0000, q.cnt};
            `TCD_OFF_PSC: rd_val = {16'h0000, q.psc};
            `TCD_OFF_CAR: rd_val = {16'h0000, q.auto_reload_value};
            `TCD_OFF_CV0: rd_val = {16'h0000, q.cv};
            `TCD_OFF_DMA_CONFIGURATION: rd_val = {19'h0_0000, q.dma_tc, 3'h0, q.dma_ta};
            `TCD_OFF_DMA_TRANSFER_BUFFER: rd_val = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
    end

    assign apb_o.prdata = q.rdata;
    assign apb_o.pready = 1'b1;
    assign apb_o.pslverr = apb_i.psel && apb_i.penable && !rd_hit;

    // ****************************************************************
    // Count source selection
    // ****************************************************************
    assign trig_c = ((q.tsel == `TCD_TS_EXT) || (q.tsel == `TCD_TS_EVT)) && trig_in;
    assign trig_rise = trig_c && !q.trg_q;
    assign halted = dbg_halt && q.hold;

    always_comb
    begin
        src_en = q.ctl0[`TCD_CEN] && !halted;
        if (q.smode == `TCD_SM_EXT1)
        begin
            src_en = src_en && trig_rise;
        end
        else if (q.smode == `TCD_SM_PAUSE)
        begin
            src_en = src_en && trig_c;
        end
    end

    tcd_tick_div #(
        .W(`TCD_CNT_W)
    ) u_presc (
        .clk(pclk),
        .rst_n(presetn),
        .en(src_en),
        .ratio(q.psc),
        .tick(pre_tick)
    );

    always_comb
    begin
        unique case (q.ctl0[`TCD_SAMPLE_CLOCK_DIVIDE])
            `TCD_SAMPLE_CLOCK_DIVIDE_2: dts_ratio = 2'h1;
            `TCD_SAMPLE_CLOCK_DIVIDE_4: dts_ratio = 2'h3;
            default: dts_ratio = 2'h0;
        endcase
    end

    tcd_tick_div #(
        .W(2)
    ) u_dts (
        .clk(pclk),
        .rst_n(presetn),
        .en(1'b1),
        .ratio(dts_ratio),
        .tick(dts_tick)
    );

    assign arr = q.ctl0[`TCD_RELOAD_SHADOW_ENABLE] ? q.car_sh : q.auto_reload_value;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        upd = 1'b0;
        cmp = 1'b0;
        d.trg_q = trig_c;
        if (apb_i.psel && !apb_i.penable && !apb_i.pwrite)
        begin
            d.rdata = rd_val;
        end
        if (wr_acc)
        begin
            unique case (a)
                `TCD_OFF_CTL0:
                begin
                    d.ctl0 = wd[`TCD_CTL0_W-1:0];
                    if (count_alignment_select != `TCD_CAM_EDGE)
                    begin
                        d.ctl0[`TCD_DIR] = q.ctl0[`TCD_DIR];
                    end
                    if (q.ctl0[`TCD_CEN] && count_alignment_select == `TCD_CAM_EDGE)
                    begin
                        d.ctl0[`TCD_CAM] = `TCD_CAM_EDGE;
                    end
                end
                `TCD_OFF_MSTR: d.mts = wd[`TCD_MSTR_F];
                `TCD_OFF_SLV:
                begin
                    d.smode = wd[`TCD_SLV_MODE];
                    d.tsel = wd[`TCD_SLV_TSEL];
                end
                `TCD_OFF_DMAEN: d.dmaen = wd[1:0];
                `TCD_OFF_STAT: d.flags = q.flags & wd[1:0];
                `TCD_OFF_DBG: d.hold = wd[0];
                `TCD_OFF_CNT: d.cnt = wd[`TCD_CNT_W-1:0];
                `TCD_OFF_PSC: d.psc = wd[`TCD_CNT_W-1:0];
                `TCD_OFF_CAR: d.auto_reload_value = wd[`TCD_CNT_W-1:0];
                `TCD_OFF_CV0: d.cv = wd[`TCD_CNT_W-1:0];
                `TCD_OFF_DMA_CONFIGURATION:
                begin
                    d.dma_ta = wd[`TCD_DCFG_TA];
                    d.dma_tc = wd[`TCD_DCFG_TC];
                end
                default: d.dma_ta = q.dma_ta;
            endcase
        end
        if (pre_tick)
        begin
            if (count_alignment_select == `TCD_CAM_EDGE)
            begin
                if (!q.ctl0[`TCD_DIR])
                begin
                    d.cnt = (q.cnt >= arr) ? '0 : q.cnt + 1'b1;
                    upd = (q.cnt >= arr);
                end
                else
                begin
                    d.cnt = (q.cnt == '0) ? arr : q.cnt - 1'b1;
                    upd = (q.cnt == '0);
                end
            end
            else if (!q.dir_hw)
            begin
                upd = (q.cnt >= arr);
                d.dir_hw = upd;
                d.cnt = upd ? q.cnt - 1'b1 : q.cnt + 1'b1;
            end
            else
            begin
                upd = (q.cnt == '0);
                d.dir_hw = !upd;
                d.cnt = upd ? q.cnt + 1'b1 : q.cnt - 1'b1;
            end
            unique case (count_alignment_select)
                `TCD_CAM_DOWN: cmp = (d.cnt == q.cv) && d.dir_hw;
                `TCD_CAM_UP: cmp = (d.cnt == q.cv) && !d.dir_hw;
                default: cmp = (d.cnt == q.cv);
            endcase
        end
        upd = upd && !q.ctl0[`TCD_UPDIS];
        d.ocref = (d.cnt < q.cv);
        if (upd)
        begin
            d.car_sh = q.auto_reload_value;
            d.flags[0] = 1'b1;
            if (q.ctl0[`TCD_SPM])
            begin
                d.ctl0[`TCD_CEN] = 1'b0;
            end
        end
        if (cmp)
        begin
            d.flags[1] = 1'b1;
        end
        if (q.smode == `TCD_SM_EVENT && trig_rise)
        begin
            d.ctl0[`TCD_CEN] = 1'b1;
        end
        unique case (q.mts)
            `TCD_MTS_RUN: d.trgo = d.ctl0[`TCD_CEN];
            `TCD_MTS_UPD: d.trgo = upd;
            `TCD_MTS_OC0: d.trgo = d.ocref;
            default: d.trgo = 1'b0;
        endcase
        if (q.dma_pend && !q.dma_req)
        begin
            d.dma_req = 1'b1;
            d.dma_pend = 1'b0;
        end
        if (tb_acc)
        begin
            d.dma_idx = q.dma_idx + 5'h01;
            d.dma_req = 1'b0;
            d.dma_pend = (q.dma_left != 5'h00);
            d.dma_left = (q.dma_left != 5'h00) ? q.dma_left - 5'h01 : 5'h00;
        end
        if ((upd && q.dmaen[0]) || (cmp && q.dmaen[1]))
        begin
            d.dma_req = 1'b1;
            d.dma_pend = 1'b0;
            d.dma_idx = 5'h00;
            d.dma_left = q.dma_tc;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.ctl0 <= `TCD_CTL0_RST;
            q.cnt <= `TCD_CNT_RST;
            q.auto_reload_value <= `TCD_CAR_RST;
            q.car_sh <= `TCD_CAR_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign trgo = q.trgo;
    assign dma_req = q.dma_req;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence tb_done_s;
        tb_acc && q.dma_left != 5'h00 && !((upd && q.dmaen[0]) || (cmp && q.dmaen[1]));
    endsequence

    sequence req_again_s;
        !dma_req ##1 dma_req;
    endsequence

    trgo_update_a: assert property ((q.mts == 3'h2) && upd |=> trgo)
        else $error("update pulse missing on trigger output");
    trgo_run_a: assert property ((q.mts == 3'h1) && $stable(q.mts) |-> trgo == $past(d.ctl0[0]))
        else $error("trigger output does not follow run bit");
    trgo_oc0_a: assert property ((q.mts == 3'h4) |=> trgo == q.ocref)
        else $error("trigger output does not follow channel 0 reference");
    event_run_a: assert property ((q.smode == 3'h3) && trig_rise |=> q.ctl0[0])
        else $error("event trigger did not set run bit");
    event_keep_a: assert property ((q.smode == 3'h3) && trig_rise && !q.ctl0[0] && !wr_acc
        |=> q.cnt == $past(q.cnt))
        else $error("event trigger altered counter");
    pause_hold_a: assert property ((q.smode == 3'h2) && !trig_c && !wr_acc
        |=> $stable(q.cnt))
        else $error("counter moved while paused");
    debug_hold_a: assert property (halted && !wr_acc |=> $stable(q.cnt))
        else $error("counter moved in debug hold");
    dma_event_a: assert property (upd && q.dmaen[0] |=> dma_req && q.dma_idx == 5'h00)
        else $error("enabled update gave no DMA request");
    burst_step_a: assert property (tb_done_s |-> ##1 req_again_s)
        else $error("burst did not issue next request");
    burst_addr_a: assert property (tb_done_s |=> q.dma_idx == $past(q.dma_idx) + 5'h01)
        else $error("burst target did not advance one word");
    cam_lock_a: assert property (q.ctl0[0] && count_alignment_select == 2'h0 |=> q.ctl0[6:5] == 2'h0)
        else $error("alignment left edge mode while running");
    dts_full_a: assert property ((q.ctl0[9:8] == 2'h0) [*2] |-> dts_tick)
        else $error("sample clock not undivided");
    dts_quarter_a: assert property ((q.ctl0[9:8] == 2'h2) && dts_tick && !wr_acc |=> !dts_tick)
        else $error("sample clock ticked twice in a row at divide by four");
endmodule : tcd_timer_ctl

//--- testbench/tcd_master_model.sv
// Purpose: Behavioural master timer that drives the chained trigger into the slave.
// Assumes: Same clock as the slave, so no synchroniser stands between them.
// Notes: Level kind follows run; pulse kind gives one-cycle pulses every four cycles.
`timescale 1ns/100ps
module tcd_master_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from the bench
    input wire logic run,
    input wire logic pulse_kind,
    // Trigger to the slave
    output logic trig
);
    logic [1:0] phase_q;

    // Pulses stand one cycle, as an update event of a real master would.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q <= 2'h0;
            trig <= 1'b0;
        end
        else
        begin
            phase_q <= run ? phase_q + 2'h1 : 2'h0;
            trig <= run && (!pulse_kind || phase_q == 2'h0);
        end
    end
endmodule : tcd_master_model

//--- testbench/tcd_timer_ctl_tb.sv
// Purpose: Self-checking bench for the timer control block.
// Assumes: Zero wait state APB slave; bench acts as CPU and as DMA controller.
// Notes: Random register data comes from a fixed-seed shift register.
`timescale 1ns/100ps
module tcd_timer_ctl_tb
    import tcd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn;
    tcd_apb_s bus;
    tcd_apb_rsp_s rsp;
    logic trig, trgo, dma_req, dbg_halt, dts_tick, run, pulse_kind, er;
    logic [31:0] rd, seed, v;
    int err_total, check_count, n, i, b;
    int mts_tab [3] = '{4, 2, 1};
    int trgo_tab [3] = '{20, 10, 40};
    int div_tab [4] = '{1, 2, 4, 1};
    logic [31:0] dma_tab [3] = '{32'h00000001, 32'h00000020, 32'h00000000};
    logic [31:0] cmp_tab [6] = '{32'h0, 32'h2, 32'h2, 32'h2, 32'h0, 32'h2};

    always #2 pclk = ~pclk;

    tcd_timer_ctl u_tcd_timer_ctl (.pclk(pclk), .presetn(presetn), .apb_i(bus), .apb_o(rsp),
        .trig_in(trig), .trgo(trgo), .dma_req(dma_req), .dbg_halt(dbg_halt),
        .dts_tick(dts_tick));
    tcd_master_model u_tcd_master_model (.pclk(pclk), .presetn(presetn), .run(run),
        .pulse_kind(pulse_kind), .trig(trig));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    // Request is held from setup until pready is seen high at an edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        bus <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        bus.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        bus.psel <= 1'b0;
        bus.penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rdchk

    task count40(input int sel);
        n = 0;
        repeat (40)
        begin
            @(posedge pclk);
            n += (sel == 0) ? trgo : (sel == 1) ? dts_tick : dma_req;
        end
    endtask : count40

    task wait_req(input int lim);
        int k;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (dma_req !== 1'b1 && k < lim);
        chk({31'h0, dma_req}, 32'h1, "dma request");
    endtask : wait_req

    task results;
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end

    initial
    begin
        bus = '0;
        dbg_halt = 1'b0;
        run = 1'b0;
        pulse_kind = 1'b0;
        presetn = 1'b0;
        err_total = 0;
        check_count = 0;
        seed = 32'd76349;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // ****************************************************************
        // Reset values, unmapped access and random read-back
        // ****************************************************************
        rdchk(8'h00, 32'h0, "ctl0 reset");
        rdchk(8'h2C, 32'h0000FFFF, "reload reset");
        rdchk(8'h24, 32'h0, "count reset");
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        chk({31'h0, er}, 32'h1, "unmapped error");
        for (i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            apb(1'b1, 8'h34, seed);
            rdchk(8'h34, {16'h0, seed[15:0]}, "compare value");
        end
        // ****************************************************************
        // Trigger output kinds
        // ****************************************************************
        apb(1'b1, 8'h2C, 32'h3);
        apb(1'b1, 8'h34, 32'h2);
        for (i = 0; i < 3; i++)
        begin
            apb(1'b1, 8'h04, 32'(mts_tab[i] << 4));
            apb(1'b1, 8'h00, 32'h1);
            cyc(8);
            count40(0);
            chk(n, trgo_tab[i], "trigger out highs");
            apb(1'b1, 8'h00, 32'h0);
        end
        cyc(4);
        chk({31'h0, trgo}, 32'h0, "run level low");
        // ****************************************************************
        // Slave modes
        // ****************************************************************
        apb(1'b1, 8'h2C, 32'hFFFF);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h08, 32'h11);
        apb(1'b1, 8'h00, 32'h1);
        pulse_kind <= 1'b1;
        run <= 1'b1;
        cyc(20);
        run <= 1'b0;
        cyc(4);
        rdchk(8'h24, 32'h5, "external clock count");
        for (i = 0; i < 2; i++)
        begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h24, 32'h10);
            apb(1'b1, 8'h08, 32'h33);
            pulse_kind <= i[0];
            run <= 1'b1;
            cyc(4);
            run <= 1'b0;
            apb(1'b0, 8'h00, 32'h0);
            chk(rd & 32'h1, 32'h1, "event sets run");
            apb(1'b0, 8'h24, 32'h0);
            chk({31'h0, rd > 32'h10 && rd < 32'h40}, 32'h1, "event resumes");
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h08, 32'h32);
        pulse_kind <= 1'b0;
        apb(1'b1, 8'h00, 32'h1);
        cyc(10);
        rdchk(8'h24, 32'h0, "pause holds");
        run <= 1'b1;
        cyc(20);
        run <= 1'b0;
        cyc(4);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, rd >= 32'd18 && rd <= 32'd22}, 32'h1, "pause counts");
        // ****************************************************************
        // Debug hold
        // ****************************************************************
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h14, 32'h1);
        dbg_halt <= 1'b1;
        cyc(2);
        apb(1'b0, 8'h24, 32'h0);
        v = rd;
        cyc(10);
        rdchk(8'h24, v, "halt holds count");
        dbg_halt <= 1'b0;
        cyc(10);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, rd != v}, 32'h1, "count runs again");
        // ****************************************************************
        // Burst DMA through the buffer register
        // ****************************************************************
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h04, 32'h20);
        apb(1'b1, 8'h2C, 32'hFF);
        apb(1'b1, 8'h48, 32'h200);
        apb(1'b1, 8'h0C, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        for (b = 0; b < 2; b++)
        begin
            for (i = 0; i < 3; i++)
            begin
                wait_req(600);
                apb(1'b0, 8'h4C, 32'h0);
                chk(rd, dma_tab[i], "burst word");
            end
            count40(2);
            chk(n, 32'h0, "no extra request");
        end
        // ****************************************************************
        // Sample clock divide and control field locks
        // ****************************************************************
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, 8'h00, {22'h0, i[1:0], 8'h0});
            cyc(4);
            count40(1);
            chk(n, 40 / div_tab[i], "sample ticks");
        end
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h21);
        rdchk(8'h00, 32'h1, "align locked");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h20);
        apb(1'b1, 8'h00, 32'h30);
        rdchk(8'h00, 32'h20, "direction read only");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h10);
        rdchk(8'h00, 32'h10, "direction writable");
        // ****************************************************************
        // Center-aligned compare flags and reload shadow
        // ****************************************************************
        apb(1'b1, 8'h2C, 32'h3);
        for (i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h24, 32'h0);
            apb(1'b1, 8'h34, (i < 3) ? 32'h3 : 32'h0);
            apb(1'b1, 8'h10, 32'h0);
            apb(1'b1, 8'h00, 32'((i % 3 + 1) << 5) | 32'h1);
            cyc(20);
            apb(1'b0, 8'h10, 32'h0);
            chk(rd & 32'h2, cmp_tab[i], "compare flag direction");
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h24, 32'hFE);
        apb(1'b1, 8'h2C, 32'hFF);
        apb(1'b1, 8'h00, 32'h81);
        apb(1'b1, 8'h2C, 32'h2);
        cyc(8);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, rd > 32'h2 && rd < 32'h40}, 32'h1, "shadow keeps reload");
        apb(1'b1, 8'h00, 32'h1);
        cyc(4);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, rd <= 32'h2}, 32'h1, "direct reload");
        results();
    end
endmodule : tcd_timer_ctl_tb
